// *** hdl/node_switch_config_regs.sv ***
`timescale 1ns/1ps
`include "node_cfg_map.svh"

module node_switch_config_regs
    import node_cfg_pkg::*;
#(
    parameter logic [7:0] CHIP_ID        = 8'h5A, // arbitrary value
    parameter logic [7:0] SWITCH_REV     = 8'h01, // arbitrary value
    parameter logic [7:0] SWITCH_VER     = 8'h01, // arbitrary value
    parameter logic [7:0] NUM_LINKS      = 8'h08,
    parameter logic [7:0] NUM_CORES      = 8'h01,
    parameter logic [7:0] LINKS_PER_CORE = 8'h04
) (
    // clock and reset
    input  wire logic         MCLK,
    input  wire logic         RESET_N,
    // boot strap pins
    input  wire logic         BOOT_STRAP_PIN_0,
    input  wire logic         BOOT_STRAP_PIN_1,
    // configuration access
    input  wire cfg_req_t     CFG_REQ,
    output cfg_rsp_t          CFG_RSP,
    // switch state shown in the link words and the debug origin word
    input  link_status_t      LINK_STATUS [`LINK_COUNT],
    input  link_status_t      CORE_LINK_STATUS [`CORE_LINK_COUNT],
    input  wire logic [1:0]   DEBUG_ORIGIN,
    // routing lookup
    input  wire logic         ROUTE_VALID,
    input  wire logic [15:0]  ROUTE_DEST,
    output logic              ROUTE_DONE,
    output logic              ROUTE_LOCAL,
    output logic [3:0]        ROUTE_DIR,
    // settings driven into the node
    output logic              SHORT_HEADER,
    output logic [15:0]       NODE_ID,
    output pll_word_t         PLL_CFG,
    output logic              TILE_RESET,
    output logic              SWITCH_TICK,
    output logic              REF_TICK,
    output logic [1:0]        DEBUG_PIN_CFG
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic in_group(input logic [7:0] a, input logic [7:0] base,
                                      input logic [7:0] n);
        in_group = (a >= base) && (a < 8'(base + n));
    endfunction : in_group

    function automatic pll_word_t pll_init(input logic [1:0] s);
        pll_word_t w;
        w = '0;
        case (s)
            2'h0: begin w.pll_output_divider = 3'h1; w.mult = 13'h0013; w.in_div = 7'h00; end
            2'h1: begin w.pll_output_divider = 3'h1; w.mult = 13'h0027; w.in_div = 7'h01; end
            2'h2: begin w.pll_output_divider = 3'h0; w.mult = 13'h0013; w.in_div = 7'h00; end
            default: begin w.pll_output_divider = 3'h0; w.mult = 13'h0009; w.in_div = 7'h00; end
        endcase
        pll_init = w;
    endfunction : pll_init

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [1:0]           strap_s1;
    logic [1:0]           strap_s2;
    logic [1:0]           strap_s3;
    logic                 captured;
    logic [1:0]           straps;
    security_word_t       security;
    logic [15:0]          node_id;
    pll_word_t            pll;
    logic [`DIV_W-1:0]    switch_div;
    logic [`DIV_W-1:0]    ref_div;
    logic [`DIV_W-1:0]    switch_cnt;
    logic [`DIV_W-1:0]    ref_cnt;
    logic [31:0]          dir_low;
    logic [31:0]          dir_high;
    logic [1:0]           debug_pin;
    logic [3:0]           link_dir [`LINK_COUNT];
    logic [1:0]           link_net [`LINK_COUNT];
    logic [1:0]           core_net [`CORE_LINK_COUNT];
    logic [31:0]          link_setup [`LINK_COUNT];
    logic [31:0]          link_static [`LINK_COUNT];
    logic [3:0]           tile_cnt;
    logic                 do_capture;
    logic                 wr;
    logic                 wr_ok;
    logic                 pll_wr_ok;
    logic [2:0]           idx;
    logic [31:0]          next_rdata;
    link_word_t           lw;

    // ------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        strap_s1 <= {BOOT_STRAP_PIN_1, BOOT_STRAP_PIN_0};
        strap_s2 <= strap_s1;
        strap_s3 <= strap_s2;
    end

    // sampled once after release, when the synchroniser has settled
    assign do_capture = !captured && (strap_s2 == strap_s3);

    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            captured <= 1'b0;
            straps   <= 2'h0;
        end else if (do_capture) begin
            captured <= 1'b1;
            straps   <= strap_s3;
        end
    end

    // ------------------------------------------------------------
    // write qualification
    // ------------------------------------------------------------
    // only configuration requests reach the registers
    assign wr    = CFG_REQ.valid && CFG_REQ.write;
    assign wr_ok = wr && !security.write_lock;
    assign pll_wr_ok = wr_ok && (CFG_REQ.addr == `OFS_PLL) && !security.pll_lock;
    assign idx   = CFG_REQ.addr[2:0];

    // ------------------------------------------------------------
    // writable registers
    // ------------------------------------------------------------
    // only defined fields are stored
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            security <= '0;
        end else if (wr_ok && CFG_REQ.addr == `OFS_SECURITY) begin
            security.write_lock   <= CFG_REQ.wdata[31];
            security.pll_lock     <= CFG_REQ.wdata[8];
            security.short_header <= CFG_REQ.wdata[0];
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            node_id <= '0;
        end else if (wr_ok && CFG_REQ.addr == `OFS_ROUTE_ID) begin
            node_id <= CFG_REQ.wdata[15:0];
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            pll <= '0;
        end else if (do_capture) begin
            pll <= pll_init(strap_s3);
        end else if (pll_wr_ok) begin
            pll.pll_output_divider <= CFG_REQ.wdata[25:23];
            pll.mult               <= CFG_REQ.wdata[20:8];
            pll.in_div             <= CFG_REQ.wdata[6:0];
        end
    end

    // tile reset after pll write, not when locked out
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            tile_cnt <= '0;
        end else if (pll_wr_ok) begin
            tile_cnt <= `TILE_RESET_LEN;
        end else if (tile_cnt != '0) begin
            tile_cnt <= tile_cnt - 4'h1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            switch_div <= `SWITCH_DIV_RESET;
            ref_div    <= `REF_DIV_RESET;
            dir_low    <= '0;
            dir_high   <= '0;
            debug_pin  <= '0;
        end else if (wr_ok) begin
            if (CFG_REQ.addr == `OFS_SWITCH_DIV) begin
                switch_div <= CFG_REQ.wdata[`DIV_W-1:0];
            end else if (CFG_REQ.addr == `OFS_REF_DIV) begin
                ref_div <= CFG_REQ.wdata[`DIV_W-1:0];
            end else if (CFG_REQ.addr == `OFS_DIR_LOW) begin
                dir_low <= CFG_REQ.wdata;
            end else if (CFG_REQ.addr == `OFS_DIR_HIGH) begin
                dir_high <= CFG_REQ.wdata;
            end else if (CFG_REQ.addr == `OFS_DEBUG_PIN) begin
                debug_pin <= CFG_REQ.wdata[1:0];
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            for (int i = 0; i < `LINK_COUNT; i++) begin
                link_dir[i]    <= '0;
                link_net[i]    <= '0;
                link_setup[i]  <= '0;
                link_static[i] <= '0;
            end
            for (int i = 0; i < `CORE_LINK_COUNT; i++) begin
                core_net[i] <= '0;
            end
        end else if (wr_ok) begin
            if (in_group(CFG_REQ.addr, `OFS_LINK_BASE, `LINK_COUNT)) begin
                link_dir[idx] <= CFG_REQ.wdata[11:8];
                link_net[idx] <= CFG_REQ.wdata[5:4];
            end else if (in_group(CFG_REQ.addr, `OFS_CORE_BASE, `CORE_LINK_COUNT)) begin
                core_net[idx[1:0]] <= CFG_REQ.wdata[5:4];
            end else if (in_group(CFG_REQ.addr, `OFS_SETUP_BASE, `LINK_COUNT)) begin
                link_setup[idx] <= CFG_REQ.wdata;
            end else if (in_group(CFG_REQ.addr, `OFS_STATIC_BASE, `LINK_COUNT)) begin
                link_static[idx] <= CFG_REQ.wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = '0;
        lw         = '0;
        if (CFG_REQ.addr == `OFS_IDENT) begin
            next_rdata = ident_word_t'{CHIP_ID, {6'h00, straps}, SWITCH_REV, SWITCH_VER};
        end else if (CFG_REQ.addr == `OFS_CAPABILITY) begin
            next_rdata = {8'h00, NUM_LINKS, NUM_CORES, LINKS_PER_CORE};
        end else if (CFG_REQ.addr == `OFS_SECURITY) begin
            next_rdata = security;
        end else if (CFG_REQ.addr == `OFS_ROUTE_ID) begin
            next_rdata = {16'h0000, node_id};
        end else if (CFG_REQ.addr == `OFS_PLL) begin
            next_rdata = pll;
        end else if (CFG_REQ.addr == `OFS_SWITCH_DIV) begin
            next_rdata = {16'h0000, switch_div};
        end else if (CFG_REQ.addr == `OFS_REF_DIV) begin
            next_rdata = {16'h0000, ref_div};
        end else if (CFG_REQ.addr == `OFS_DIR_LOW) begin
            next_rdata = dir_low;
        end else if (CFG_REQ.addr == `OFS_DIR_HIGH) begin
            next_rdata = dir_high;
        end else if (CFG_REQ.addr == `OFS_DEBUG_PIN) begin
            next_rdata = {30'h0, debug_pin};
        end else if (CFG_REQ.addr == `OFS_DEBUG_ORIGIN) begin
            next_rdata = {27'h0, DEBUG_ORIGIN[1], 3'h0, DEBUG_ORIGIN[0]};
        end else if (in_group(CFG_REQ.addr, `OFS_LINK_BASE, `LINK_COUNT)) begin
            lw.kind     = LINK_STATUS[idx].kind;
            lw.dest     = LINK_STATUS[idx].dest;
            lw.dir      = link_dir[idx];
            lw.net      = link_net[idx];
            lw.junk     = LINK_STATUS[idx].junk;
            lw.out_busy = LINK_STATUS[idx].out_busy;
            lw.in_busy  = LINK_STATUS[idx].in_busy;
            next_rdata  = lw;
        end else if (in_group(CFG_REQ.addr, `OFS_CORE_BASE, `CORE_LINK_COUNT)) begin
            lw.kind     = CORE_LINK_STATUS[idx[1:0]].kind;
            lw.dest     = CORE_LINK_STATUS[idx[1:0]].dest;
            lw.net      = core_net[idx[1:0]];
            lw.junk     = CORE_LINK_STATUS[idx[1:0]].junk;
            lw.out_busy = CORE_LINK_STATUS[idx[1:0]].out_busy;
            lw.in_busy  = CORE_LINK_STATUS[idx[1:0]].in_busy;
            next_rdata  = lw;
        end else if (in_group(CFG_REQ.addr, `OFS_SETUP_BASE, `LINK_COUNT)) begin
            next_rdata = link_setup[idx];
        end else if (in_group(CFG_REQ.addr, `OFS_STATIC_BASE, `LINK_COUNT)) begin
            next_rdata = link_static[idx];
        end
    end

    // refused writes still answer, so the master never waits forever
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            CFG_RSP <= '0;
        end else begin
            CFG_RSP.ack     <= CFG_REQ.valid;
            CFG_RSP.refused <= wr && (security.write_lock
                               || (CFG_REQ.addr == `OFS_PLL && security.pll_lock));
            CFG_RSP.rdata   <= (CFG_REQ.valid && !CFG_REQ.write) ? next_rdata : '0;
        end
    end

    // ------------------------------------------------------------
    // clock division
    // ------------------------------------------------------------
    // switch clock tick every divider+1 cycles
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            switch_cnt  <= '0;
            SWITCH_TICK <= 1'b0;
        end else begin
            SWITCH_TICK <= (switch_cnt >= switch_div);
            switch_cnt  <= (switch_cnt >= switch_div) ? '0 : switch_cnt + 16'h0001;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            ref_cnt  <= '0;
            REF_TICK <= 1'b0;
        end else begin
            REF_TICK <= (ref_cnt >= ref_div);
            ref_cnt  <= (ref_cnt >= ref_div) ? '0 : ref_cnt + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // routing lookup
    // ------------------------------------------------------------
    // most significant mismatch picks direction
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            ROUTE_DONE  <= 1'b0;
            ROUTE_LOCAL <= 1'b0;
            ROUTE_DIR   <= '0;
        end else begin
            ROUTE_DONE  <= ROUTE_VALID;
            ROUTE_LOCAL <= ROUTE_VALID && (ROUTE_DEST == node_id);
            ROUTE_DIR   <= '0;
            for (int b = 0; b < 16; b++) begin
                if (ROUTE_VALID && (ROUTE_DEST[b] != node_id[b])) begin
                    ROUTE_DIR <= (b < `HALF_ID)
                        ? dir_low[b*`DIR_W +: `DIR_W]
                        : dir_high[(b-`HALF_ID)*`DIR_W +: `DIR_W];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // settings handed to the pll and the rest of the node
    assign PLL_CFG       = pll;
    assign SHORT_HEADER  = security.short_header;
    assign NODE_ID       = node_id;
    assign TILE_RESET    = (tile_cnt != '0);
    assign DEBUG_PIN_CFG = debug_pin;

endmodule : node_switch_config_regs

// *** include/node_cfg_map.svh ***
`ifndef NODE_CFG_MAP_SVH
`define NODE_CFG_MAP_SVH

// ------------------------------------------------------------
// register indices
// ------------------------------------------------------------
`define OFS_IDENT        8'h00
`define OFS_CAPABILITY   8'h01
`define OFS_SECURITY     8'h04
`define OFS_ROUTE_ID     8'h05
`define OFS_PLL          8'h06
`define OFS_SWITCH_DIV   8'h07
`define OFS_REF_DIV      8'h08
`define OFS_DIR_LOW      8'h0C
`define OFS_DIR_HIGH     8'h0D
`define OFS_DEBUG_PIN    8'h10
`define OFS_DEBUG_ORIGIN 8'h1F
`define OFS_LINK_BASE    8'h20
`define OFS_CORE_BASE    8'h40
`define OFS_SETUP_BASE   8'h80
`define OFS_STATIC_BASE  8'hA0

// ------------------------------------------------------------
// sizes and reset values
// ------------------------------------------------------------
`define LINK_COUNT       8'h08
`define CORE_LINK_COUNT  8'h04
`define DIV_W            16
`define SWITCH_DIV_RESET 16'h0000
`define REF_DIV_RESET    16'h0003
`define TILE_RESET_LEN   4'hF
`define DIR_W            4
`define HALF_ID          8

`endif

// *** include/node_cfg_pkg.sv ***
package node_cfg_pkg;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } cfg_req_t;

    typedef struct packed {
        logic        ack;
        logic        refused;
        logic [31:0] rdata;
    } cfg_rsp_t;

    typedef struct packed {
        logic [7:0] chip;
        logic [7:0] straps;
        logic [7:0] revision;
        logic [7:0] version;
    } ident_word_t;

    typedef struct packed {
        logic        write_lock;
        logic [21:0] rsv_hi;
        logic        pll_lock;
        logic [6:0]  rsv_lo;
        logic        short_header;
    } security_word_t;

    typedef struct packed {
        logic [5:0]  rsv_hi;
        logic [2:0]  pll_output_divider;
        logic [1:0]  rsv_mid;
        logic [12:0] mult;
        logic        rsv_lo;
        logic [6:0]  in_div;
    } pll_word_t;

    typedef struct packed {
        logic [1:0] kind;
        logic [7:0] dest;
        logic       junk;
        logic       out_busy;
        logic       in_busy;
    } link_status_t;

    typedef struct packed {
        logic [5:0] rsv_a;
        logic [1:0] kind;
        logic [7:0] dest;
        logic [3:0] rsv_b;
        logic [3:0] dir;
        logic [1:0] rsv_c;
        logic [1:0] net;
        logic       rsv_d;
        logic       junk;
        logic       out_busy;
        logic       in_busy;
    } link_word_t;

endpackage : node_cfg_pkg

// *** testbench/cfg_master.sv ***
`timescale 1ns/1ps

module cfg_master
    import node_cfg_pkg::*;
(
    // clock
    input  wire logic     clk,
    // request and response
    output cfg_req_t      req,
    input  wire cfg_rsp_t rsp
);
    // idle cycles added before each request beyond the one always left, raised for a slow master
    int gap = 0;

    initial req = '0;

    // ------------------------------------------------------------
    // configuration transactions only
    // ------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output cfg_rsp_t r);
        repeat (gap + 1) @(posedge clk);
        #1 req = '{1'b1, wr, a, d};
        @(posedge clk);
        #1 r = rsp;
        // released lines must not keep showing the old request
        req = '{1'b0, ~wr, ~a, ~d};
    endtask : xfer
endmodule : cfg_master

// *** testbench/node_cfg_chk.sv ***
`timescale 1ns/1ps

module node_cfg_chk
    import node_cfg_pkg::*;
(
    // clock and reset
    input  wire logic        MCLK,
    input  wire logic        RESET_N,
    // configuration access
    input  wire cfg_req_t    CFG_REQ,
    input  wire cfg_rsp_t    CFG_RSP,
    // routing
    input  wire logic        ROUTE_VALID,
    input  wire logic [15:0] ROUTE_DEST,
    input  wire logic        ROUTE_DONE,
    input  wire logic        ROUTE_LOCAL,
    // settings
    input  wire logic        SHORT_HEADER,
    input  wire logic [15:0] NODE_ID,
    input  wire pll_word_t   PLL_CFG,
    input  wire logic        TILE_RESET
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESET_N);

    sequence wr_ok(logic [7:0] a);
        CFG_REQ.valid && CFG_REQ.write && CFG_REQ.addr == a ##1 CFG_RSP.ack && !CFG_RSP.refused;
    endsequence

    ack_one_cycle_a: assert property (CFG_REQ.valid |=> CFG_RSP.ack)
        else $error("no acknowledge one cycle after a request");
    ack_has_cause_a: assert property (!$past(CFG_REQ.valid) |-> !CFG_RSP.ack)
        else $error("acknowledge without a request");
    refuse_on_write_a: assert property (CFG_RSP.refused |-> CFG_RSP.ack && $past(CFG_REQ.write))
        else $error("refusal not tied to a write");
    refused_no_change_a: assert property (CFG_RSP.refused |->
        $stable(NODE_ID) && $stable(PLL_CFG) && $stable(SHORT_HEADER))
        else $error("refused write changed a setting");
    node_id_write_a: assert property (wr_ok(8'h05) |-> NODE_ID == $past(CFG_REQ.wdata[15:0]))
        else $error("node id not taken from write");
    header_write_a: assert property (wr_ok(8'h04) |-> SHORT_HEADER == $past(CFG_REQ.wdata[0]))
        else $error("header mode not taken from write");
    pll_write_a: assert property (wr_ok(8'h06) |-> PLL_CFG == ($past(CFG_REQ.wdata) & 32'h039F_FF7F))
        else $error("pll fields not taken from write");
    tile_reset_hold_a: assert property (wr_ok(8'h06) |-> TILE_RESET [*8])
        else $error("tile reset missing after pll write");
    tile_reset_cause_a: assert property ($rose(TILE_RESET) |->
        CFG_RSP.ack && !CFG_RSP.refused && $past(CFG_REQ.addr) == 8'h06)
        else $error("tile reset without accepted pll write");
    route_match_a: assert property (ROUTE_VALID |=>
        ROUTE_DONE && ROUTE_LOCAL == ($past(ROUTE_DEST) == $past(NODE_ID)))
        else $error("route result wrong");
    id_upper_zero_a: assert property (CFG_REQ.valid && !CFG_REQ.write && CFG_REQ.addr == 8'h05
        |=> CFG_RSP.rdata == {16'h0000, NODE_ID})
        else $error("node id read wrong");

    cover property (CFG_RSP.refused);
    cover property (ROUTE_DONE && ROUTE_LOCAL);
    cover property ($rose(TILE_RESET));
endmodule : node_cfg_chk

bind node_switch_config_regs node_cfg_chk u_chk (
    .MCLK         (MCLK),
    .RESET_N      (RESET_N),
    .CFG_REQ      (CFG_REQ),
    .CFG_RSP      (CFG_RSP),
    .ROUTE_VALID  (ROUTE_VALID),
    .ROUTE_DEST   (ROUTE_DEST),
    .ROUTE_DONE   (ROUTE_DONE),
    .ROUTE_LOCAL  (ROUTE_LOCAL),
    .SHORT_HEADER (SHORT_HEADER),
    .NODE_ID      (NODE_ID),
    .PLL_CFG      (PLL_CFG),
    .TILE_RESET   (TILE_RESET)
);

// *** testbench/testbench.sv ***
`timescale 1ns/1ps

module testbench
    import node_cfg_pkg::*;
;
    logic         MCLK = 1'b0;
    logic         RESET_N = 1'b0;
    logic         BOOT_STRAP_PIN_0 = 1'b0;
    logic         BOOT_STRAP_PIN_1 = 1'b1;
    cfg_req_t     CFG_REQ;
    cfg_rsp_t     CFG_RSP;
    link_status_t LINK_STATUS [8];
    link_status_t CORE_LINK_STATUS [4];
    logic [1:0]   DEBUG_ORIGIN = 2'b10;
    logic         ROUTE_VALID = 1'b0;
    logic [15:0]  ROUTE_DEST = 16'h0000;
    logic         ROUTE_DONE, ROUTE_LOCAL, SHORT_HEADER, TILE_RESET, SWITCH_TICK, REF_TICK;
    logic [3:0]   ROUTE_DIR;
    logic [15:0]  NODE_ID;
    pll_word_t    PLL_CFG;
    logic [1:0]   DEBUG_PIN_CFG;
    int           error_cnt = 0;
    int           n_tests = 0;
    int           cycles = 0;
    cfg_rsp_t     r;

    // identity values are arbitrary
    node_switch_config_regs #(.CHIP_ID(8'h3C), .SWITCH_REV(8'h21), .SWITCH_VER(8'h07)) u_dut (
        .MCLK(MCLK), .RESET_N(RESET_N), .BOOT_STRAP_PIN_0(BOOT_STRAP_PIN_0),
        .BOOT_STRAP_PIN_1(BOOT_STRAP_PIN_1), .CFG_REQ(CFG_REQ), .CFG_RSP(CFG_RSP),
        .LINK_STATUS(LINK_STATUS), .CORE_LINK_STATUS(CORE_LINK_STATUS),
        .DEBUG_ORIGIN(DEBUG_ORIGIN), .ROUTE_VALID(ROUTE_VALID), .ROUTE_DEST(ROUTE_DEST),
        .ROUTE_DONE(ROUTE_DONE), .ROUTE_LOCAL(ROUTE_LOCAL), .ROUTE_DIR(ROUTE_DIR),
        .SHORT_HEADER(SHORT_HEADER), .NODE_ID(NODE_ID), .PLL_CFG(PLL_CFG),
        .TILE_RESET(TILE_RESET), .SWITCH_TICK(SWITCH_TICK), .REF_TICK(REF_TICK),
        .DEBUG_PIN_CFG(DEBUG_PIN_CFG)
    );

    cfg_master u_master (.clk(MCLK), .req(CFG_REQ), .rsp(CFG_RSP));

    always #10 MCLK = ~MCLK;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            $display("[ERR] %0t ns: run did not finish in time", $time);
            finish_test();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ref_exp);
        u_master.xfer(1'b1, a, d, r);
        check({31'h0, r.ack}, 32'h0000_0001);
        check({31'h0, r.refused}, {31'h0, ref_exp});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        u_master.xfer(1'b0, a, 32'h0000_0000, r);
        check({31'h0, r.ack}, 32'h0000_0001);
        check(r.rdata, exp);
    endtask : rd

    task automatic route(input logic [15:0] dest, input logic [3:0] dir, input logic loc_exp);
        @(posedge MCLK);
        #1 ROUTE_VALID = 1'b1;
        ROUTE_DEST = dest;
        @(posedge MCLK);
        #1 ROUTE_VALID = 1'b0;
        ROUTE_DEST = ~dest;
        check({26'h0, ROUTE_DONE, ROUTE_LOCAL, ROUTE_DIR}, {26'h0, 1'b1, loc_exp, dir});
    endtask : route

    // any 24-cycle window holds whole periods of 1, 3 and 4 cycles
    task automatic ticks(input logic [31:0] n_sw, input logic [31:0] n_ref);
        logic [31:0] s = 32'h0;
        logic [31:0] f = 32'h0;
        repeat (4) @(posedge MCLK);
        repeat (24) begin
            @(posedge MCLK);
            #1 s = s + {31'h0, SWITCH_TICK};
            f = f + {31'h0, REF_TICK};
        end
        check(s, n_sw);
        check(f, n_ref);
    endtask : ticks

    initial begin
        logic [31:0] n;
        for (int i = 0; i < 8; i++) LINK_STATUS[i] = '{2'h2, 8'(8'h30 + i), 1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 4; i++) CORE_LINK_STATUS[i] = '{2'h1, 8'(i), 1'b0, 1'b1, 1'b0};
        repeat (10) @(posedge MCLK);
        #1 RESET_N = 1'b1;
        repeat (3) @(posedge MCLK);
        rd(8'h00, 32'h3C02_2107);
        rd(8'h01, 32'h0008_0104);
        check(32'(PLL_CFG), 32'h0000_1300);
        rd(8'h06, 32'h0000_1300);
        rd(8'h05, 32'h0000_0000);
        rd(8'h08, 32'h0000_0003);
        rd(8'h30, 32'h0000_0000);
        wr(8'h00, 32'hFFFF_FFFF, 1'b0);
        rd(8'h00, 32'h3C02_2107);
        ticks(32'h18, 32'h6);
        wr(8'h07, 32'hFFFF_0002, 1'b0);
        rd(8'h07, 32'h0000_0002);
        ticks(32'h8, 32'h6);
        wr(8'h05, 32'hFFFF_A5C3, 1'b0);
        rd(8'h05, 32'h0000_A5C3);
        wr(8'h0C, 32'h7654_3210, 1'b0);
        wr(8'h0D, 32'hFEDC_BA98, 1'b0);
        for (int b = 0; b < 16; b++) begin
            route(16'hA5C3 ^ 16'((32'h2 << b) - 32'h1), 4'(b), 1'b0);
        end
        route(16'hA5C3, 4'h0, 1'b1);
        for (int i = 0; i < 8; i++) begin
            wr(8'(8'h20 + i), 32'hFFFF_FFFF, 1'b0);
            rd(8'(8'h20 + i), {8'h02, 8'(8'h30 + i), 16'h0F35});
        end
        for (int i = 0; i < 4; i++) begin
            wr(8'(8'h40 + i), 32'hFFFF_FFFF, 1'b0);
            rd(8'(8'h40 + i), {8'h01, 8'(i), 16'h0032});
        end
        wr(8'hA7, 32'hDEAD_BEEF, 1'b0);
        rd(8'hA7, 32'hDEAD_BEEF);
        wr(8'h10, 32'hFFFF_FFFF, 1'b0);
        check({30'h0, DEBUG_PIN_CFG}, 32'h0000_0003);
        rd(8'h1F, 32'h0000_0010);
        u_master.gap = 3;
        wr(8'h06, 32'hFFFF_FFFF, 1'b0);
        check(32'(PLL_CFG), 32'h039F_FF7F);
        n = 32'h0;
        while (TILE_RESET === 1'b1 && n < 32'h28) begin
            n = n + 32'h1;
            @(posedge MCLK);
            #1;
        end
        check(n, 32'hF);
        u_master.gap = 0;
        // single node, so header mode is set once for the system
        wr(8'h04, 32'h7FFF_FFFF, 1'b0);
        check({31'h0, SHORT_HEADER}, 32'h0000_0001);
        rd(8'h04, 32'h0000_0101);
        wr(8'h06, 32'h0000_0000, 1'b1);
        check({31'h0, TILE_RESET}, 32'h0000_0000);
        check(32'(PLL_CFG), 32'h039F_FF7F);
        wr(8'h04, 32'hFFFF_FFFF, 1'b0);
        wr(8'h05, 32'h0000_1234, 1'b1);
        wr(8'h04, 32'h0000_0000, 1'b1);
        rd(8'h05, 32'h0000_A5C3);
        rd(8'h04, 32'h8000_0101);
        finish_test();
    end
endmodule : testbench
